// file: verilog/svca_regs.sv
`timescale 1ns/100ps

// Notes on behaviour
// - Control bit 5 enables odd-field copy signalling, bit 4 enables its automatic checksum.
// - Control bit 6 enables even-field copy signalling and bit 7 enables wide screen output.
// - Control bits 3:0 carry payload bits 19:16, mid bits 7:6 carry 15:14, mid bits 5:0 13:8.
// - The low payload register carries payload bits 7:0 for either signalling kind.
// - Luma scale is the luma MSB register over bits 1:0 of the shared LSB register.
// - Blue chroma scale is its MSB register over bits 3:2 of the shared LSB register.
// - Red chroma scale is its MSB register over bits 5:4 of the shared LSB register.
// - Bits 7:6 of the shared LSB register are the two low bits of the subcarrier phase.
// - The phase high byte comes from outside this bank and joins the two phase LSBs.
// - Hue is a full byte, brightness is seven bits, and bit 7 blanks the wide screen data.
// - The shaping-filter gain code runs from -4 dB at 0000 through 0 dB at 0110 to +4 dB at 1100.
// - The shaping-filter gain is applied only while the external enable bit is one.
// - Border coring code n gives +n/16 in sharpness mode and -n/8 in noise-reduction mode.
// - Data coring code n gives +n/16 in sharpness mode and -n/8 in noise-reduction mode.
module svca_regs
	import svca_pkg::*;
#(
	parameter int REG_COUNT = SVCA_REG_COUNT
) (
	input  wire logic                  clk,
	input  wire logic                  reset,
	input  wire svca_access_t          access,
	input  wire logic            [7:0] phase_msbs,
	input  wire logic                  luma_shaping_filter_enable,
	input  wire logic                  noise_reduction_sharpness_mode,
	output logic                 [7:0] rdata,
	output logic                       read_valid,
	output logic                       address_hit,
	output svca_vbi_cfg_t              vbi_cfg,
	output svca_color_cfg_t            color_cfg
);

	// ------------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------------
	logic [7:0] offset;
	logic [3:0] index;

	always_comb begin
		offset = access.sub_address_bits - SVCA_BASE_ADDR;
		index  = offset[3:0];
		// Addresses outside the bank are left to the neighbouring blocks.
		address_hit = (access.sub_address_bits >= SVCA_BASE_ADDR)
			&& (access.sub_address_bits <= SVCA_LAST_ADDR);
	end

	// ------------------------------------------------------------------
	// Register storage
	// ------------------------------------------------------------------
	logic [7:0] bank_reg  [REG_COUNT];
	logic [7:0] bank_next [REG_COUNT];

	genvar entry;
	generate
		for (entry = 0; entry < REG_COUNT; entry++) begin : g_entry
			localparam logic [7:0] MASK = (entry == SVCA_IDX_SHAPE) ?
				SVCA_MASK_SHAPE : SVCA_MASK_FULL;

			always_comb begin
				bank_next[entry] = bank_reg[entry];
				if (access.write_strobe && address_hit && (index == 4'(entry))) begin
					bank_next[entry] = access.wdata & MASK;
				end
			end

			always_ff @(posedge clk) begin
				if (reset) begin
					bank_reg[entry] <= SVCA_RESET_VALUE;
				end else begin
					bank_reg[entry] <= bank_next[entry];
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------------
	// Read port
	// ------------------------------------------------------------------
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;
	logic       read_valid_reg;
	logic       read_valid_next;

	always_comb begin
		rdata_next      = rdata_reg;
		read_valid_next = access.read_strobe;
		if (access.read_strobe) begin
			// Unmapped addresses answer with zero.
			rdata_next = address_hit ? bank_reg[index] : 8'h00;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			rdata_reg      <= 8'h00;
			read_valid_reg <= 1'b0;
		end else begin
			rdata_reg      <= rdata_next;
			read_valid_reg <= read_valid_next;
		end
	end

	assign rdata      = rdata_reg;
	assign read_valid = read_valid_reg;

	// ------------------------------------------------------------------
	// Gain decoding
	// ------------------------------------------------------------------
	logic signed [5:0] border_gain;
	logic signed [5:0] data_gain;

	svca_coring_decode u_border_decode (
		.code            (bank_reg[SVCA_IDX_CORING][3:0]),
		.sharpness_mode  (noise_reduction_sharpness_mode),
		.gain_sixteenths (border_gain)
	);

	svca_coring_decode u_data_decode (
		.code            (bank_reg[SVCA_IDX_CORING][7:4]),
		.sharpness_mode  (noise_reduction_sharpness_mode),
		.gain_sixteenths (data_gain)
	);

	logic [3:0] shape_code;

	always_comb begin
		shape_code = bank_reg[SVCA_IDX_SHAPE][3:0];
		// Codes past the +4 dB step saturate there.
		if (shape_code > SVCA_SHAPE_CODE_MAX) begin
			shape_code = SVCA_SHAPE_CODE_MAX;
		end
	end

	// ------------------------------------------------------------------
	// Decoded configuration
	// ------------------------------------------------------------------
	svca_vbi_cfg_t   vbi_reg;
	svca_vbi_cfg_t   vbi_next;
	svca_color_cfg_t color_reg;
	svca_color_cfg_t color_next;

	always_comb begin
		vbi_next.wss_enable       = bank_reg[SVCA_IDX_CTRL][SVCA_BIT_WSS_ENABLE];
		vbi_next.cgms_even_enable = bank_reg[SVCA_IDX_CTRL][SVCA_BIT_CGMS_EVEN];
		vbi_next.cgms_odd_enable  = bank_reg[SVCA_IDX_CTRL][SVCA_BIT_CGMS_ODD];
		vbi_next.cgms_crc_enable  = bank_reg[SVCA_IDX_CTRL][SVCA_BIT_CGMS_CRC];
		vbi_next.wss_blank        = bank_reg[SVCA_IDX_BRIGHT][SVCA_BIT_WSS_BLANK];
		vbi_next.cgms_payload     = {bank_reg[SVCA_IDX_CTRL][3:0],
			bank_reg[SVCA_IDX_MID][7:6],
			bank_reg[SVCA_IDX_MID][5:0],
			bank_reg[SVCA_IDX_LOW]};
		vbi_next.wss_payload      = {bank_reg[SVCA_IDX_MID][5:0],
			bank_reg[SVCA_IDX_LOW]};
	end

	always_comb begin
		color_next.luma_scale        = {bank_reg[SVCA_IDX_LUMA],
			bank_reg[SVCA_IDX_LSBS][1:0]};
		color_next.blue_chroma_scale = {bank_reg[SVCA_IDX_BLUE],
			bank_reg[SVCA_IDX_LSBS][3:2]};
		color_next.red_chroma_scale  = {bank_reg[SVCA_IDX_RED],
			bank_reg[SVCA_IDX_LSBS][5:4]};
		color_next.subcarrier_phase  = {phase_msbs,
			bank_reg[SVCA_IDX_LSBS][7:6]};
		color_next.hue_adjust        = bank_reg[SVCA_IDX_HUE];
		color_next.brightness        = bank_reg[SVCA_IDX_BRIGHT][6:0];
		color_next.luma_shaping_filter_active = luma_shaping_filter_enable;
		if (luma_shaping_filter_enable) begin
			color_next.luma_shaping_filter_code  = shape_code;
			color_next.luma_shaping_filter_steps =
				signed'({1'b0, shape_code}) - signed'({1'b0, SVCA_SHAPE_CODE_UNITY});
		end else begin
			// With the filter disabled the gain stays at unity.
			color_next.luma_shaping_filter_code  = SVCA_SHAPE_CODE_UNITY;
			color_next.luma_shaping_filter_steps = 5'sd0;
		end
		color_next.border_coring_gain = border_gain;
		color_next.data_coring_gain   = data_gain;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			vbi_reg   <= '0;
			color_reg <= '0;
		end else begin
			vbi_reg   <= vbi_next;
			color_reg <= color_next;
		end
	end

	assign vbi_cfg   = vbi_reg;
	assign color_cfg = color_reg;

endmodule

// file: verilog/svca_pkg.sv
package svca_pkg;

	// ------------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------------
	localparam int        SVCA_REG_COUNT = 11;
	localparam logic [7:0] SVCA_BASE_ADDR = 8'h99;
	localparam logic [7:0] SVCA_LAST_ADDR = 8'ha3;

	localparam logic [7:0] SVCA_VBI_SIGNALLING_CONTROL  = 8'h99;
	localparam logic [7:0] SVCA_VBI_PAYLOAD_MID         = 8'h9a;
	localparam logic [7:0] SVCA_VBI_PAYLOAD_LOW         = 8'h9b;
	localparam logic [7:0] SVCA_SCALE_AND_PHASE_LSBS    = 8'h9c;
	localparam logic [7:0] SVCA_LUMA_SCALE_MSBS         = 8'h9d;
	localparam logic [7:0] SVCA_BLUE_CHROMA_SCALE_MSBS  = 8'h9e;
	localparam logic [7:0] SVCA_RED_CHROMA_SCALE_MSBS   = 8'h9f;
	localparam logic [7:0] SVCA_HUE_ADJUST              = 8'ha0;
	localparam logic [7:0] SVCA_BRIGHTNESS_AND_BLANKING = 8'ha1;
	localparam logic [7:0] SVCA_LUMA_SHAPING_GAIN       = 8'ha2;
	localparam logic [7:0] SVCA_CORING_GAIN             = 8'ha3;

	// Entry indices inside the bank, counted from the base address.
	localparam int SVCA_IDX_CTRL   = 0;
	localparam int SVCA_IDX_MID    = 1;
	localparam int SVCA_IDX_LOW    = 2;
	localparam int SVCA_IDX_LSBS   = 3;
	localparam int SVCA_IDX_LUMA   = 4;
	localparam int SVCA_IDX_BLUE   = 5;
	localparam int SVCA_IDX_RED    = 6;
	localparam int SVCA_IDX_HUE    = 7;
	localparam int SVCA_IDX_BRIGHT = 8;
	localparam int SVCA_IDX_SHAPE  = 9;
	localparam int SVCA_IDX_CORING = 10;

	localparam logic [7:0] SVCA_RESET_VALUE   = 8'h00;
	localparam logic [7:0] SVCA_MASK_FULL     = 8'hff;
	localparam logic [7:0] SVCA_MASK_SHAPE    = 8'h0f;

	// ------------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------------
	localparam int SVCA_BIT_WSS_ENABLE     = 7;
	localparam int SVCA_BIT_CGMS_EVEN      = 6;
	localparam int SVCA_BIT_CGMS_ODD       = 5;
	localparam int SVCA_BIT_CGMS_CRC       = 4;
	localparam int SVCA_BIT_WSS_BLANK      = 7;

	// ------------------------------------------------------------------
	// Gain codes
	// ------------------------------------------------------------------
	localparam logic [3:0] SVCA_SHAPE_CODE_MIN   = 4'h0;
	localparam logic [3:0] SVCA_SHAPE_CODE_UNITY = 4'h6;
	localparam logic [3:0] SVCA_SHAPE_CODE_MAX   = 4'hc;
	localparam logic [3:0] SVCA_CORING_CODE_MAX  = 4'h8;

	// ------------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [7:0] sub_address_bits;
		logic [7:0] wdata;
		logic       write_strobe;
		logic       read_strobe;
	} svca_access_t;

	typedef struct packed {
		logic        wss_enable;
		logic        cgms_even_enable;
		logic        cgms_odd_enable;
		logic        cgms_crc_enable;
		logic        wss_blank;
		logic [19:0] cgms_payload;
		logic [13:0] wss_payload;
	} svca_vbi_cfg_t;

	typedef struct packed {
		logic [9:0]        luma_scale;
		logic [9:0]        blue_chroma_scale;
		logic [9:0]        red_chroma_scale;
		logic [9:0]        subcarrier_phase;
		logic [7:0]        hue_adjust;
		logic [6:0]        brightness;
		logic              luma_shaping_filter_active;
		logic [3:0]        luma_shaping_filter_code;
		logic signed [4:0] luma_shaping_filter_steps;
		logic signed [5:0] border_coring_gain;
		logic signed [5:0] data_coring_gain;
	} svca_color_cfg_t;

endpackage

// file: verilog/svca_coring_decode.sv
`timescale 1ns/100ps

// Turns a four-bit coring code into a signed gain counted in sixteenths.
module svca_coring_decode
	import svca_pkg::*;
(
	input  wire logic              [3:0] code,
	input  wire logic                    sharpness_mode,
	output logic signed            [5:0] gain_sixteenths
);

	logic [3:0] code_clamped;

	always_comb begin
		// Codes above eight are undefined; they saturate at the top step.
		code_clamped = (code > SVCA_CORING_CODE_MAX) ? SVCA_CORING_CODE_MAX : code;
		if (sharpness_mode) begin
			gain_sixteenths = signed'({2'b00, code_clamped});
		end else begin
			gain_sixteenths = -signed'({1'b0, code_clamped, 1'b0});
		end
	end

endmodule

// file: tb/svca_regs_sva.sv
`timescale 1ns/100ps
module svca_regs_sva
	import svca_pkg::*;
(
	input  wire logic            clk,
	input  wire logic            reset,
	input  wire svca_access_t    access,
	input  wire logic      [7:0] phase_msbs,
	input  wire logic            luma_shaping_filter_enable,
	input  wire logic      [7:0] rdata,
	input  wire logic            read_valid,
	input  wire logic            address_hit,
	input  wire svca_vbi_cfg_t   vbi_cfg,
	input  wire svca_color_cfg_t color_cfg
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	sequence wr_s(logic [7:0] a);
		access.write_strobe && access.sub_address_bits == a;
	endsequence
	read_pulse_a: assert property (access.read_strobe |=> read_valid)
		else $error("read strobe gave no valid pulse");
	read_idle_a: assert property (!access.read_strobe |=> !read_valid)
		else $error("valid pulse without a read");
	unmapped_read_a: assert property (access.read_strobe && !address_hit |=> rdata == 8'h00)
		else $error("unmapped read returned data");
	hit_range_a: assert property (address_hit == (access.sub_address_bits inside {[8'h99:8'ha3]}))
		else $error("address decode wrong");
	rdata_hold_a: assert property (!access.read_strobe |=> $stable(rdata))
		else $error("read data moved without a read");
	luma_write_a: assert property (wr_s(8'h9d) |=> ##1 color_cfg.luma_scale[9:2] == $past(access.wdata, 2))
		else $error("luma scale high byte not loaded");
	ctrl_write_a: assert property (wr_s(8'h99) |=> ##1 {vbi_cfg.wss_enable, vbi_cfg.cgms_even_enable,
		vbi_cfg.cgms_odd_enable, vbi_cfg.cgms_crc_enable, vbi_cfg.cgms_payload[19:16]}
		== $past(access.wdata, 2))
		else $error("control byte not reflected");
	phase_join_a: assert property (!$past(reset) |-> color_cfg.subcarrier_phase[9:2] == $past(phase_msbs))
		else $error("phase high byte not joined");
	shape_gate_a: assert property (!$past(reset) |-> color_cfg.luma_shaping_filter_active
		== $past(luma_shaping_filter_enable))
		else $error("shaping gate does not follow enable");
endmodule

// file: tb/svca_regs_tb_top.sv
`timescale 1ns/100ps
module svca_regs_tb_top
	import svca_pkg::*;
;
	typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] r;} svca_row_t;
	logic            clk;
	logic            reset;
	logic            lsf_en;
	logic            sharp;
	logic      [7:0] phase;
	svca_access_t    acc;
	logic      [7:0] rdata;
	logic            rv;
	logic            hit;
	svca_vbi_cfg_t   vbi;
	svca_color_cfg_t col;
	int              bad_count;
	int              comparisons;
	int              i;
	int              n;
	int              m;
	svca_row_t       rows [13] = '{'{8'h99, 8'ha5, 8'ha5}, '{8'h9a, 8'hc3, 8'hc3},
		'{8'h9b, 8'h5a, 8'h5a}, '{8'h9c, 8'he4, 8'he4}, '{8'h9d, 8'h81, 8'h81},
		'{8'h9e, 8'h7f, 8'h7f}, '{8'h9f, 8'h10, 8'h10}, '{8'ha0, 8'h3c, 8'h3c},
		'{8'ha1, 8'h9b, 8'h9b}, '{8'ha2, 8'hf9, 8'h09}, '{8'ha3, 8'h83, 8'h83},
		'{8'ha4, 8'hff, 8'h00}, '{8'h98, 8'hff, 8'h00}};

	svca_regs svca_regs_inst (.clk(clk), .reset(reset), .access(acc), .phase_msbs(phase),
		.luma_shaping_filter_enable(lsf_en), .noise_reduction_sharpness_mode(sharp),
		.rdata(rdata), .read_valid(rv), .address_hit(hit), .vbi_cfg(vbi), .color_cfg(col));

	task chk(input logic signed [31:0] s, input logic signed [31:0] e);
		comparisons++;
		if (s !== e) begin
			bad_count++;
			$display("Error at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		acc <= '{a, d, 1'b1, 1'b0};
		@(posedge clk);
		acc.write_strobe <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		acc <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk);
		acc.read_strobe <= 1'b0;
		#1;
		chk(rdata, e);
		chk(rv, 1'b1);
	endtask
	task settle;
		@(posedge clk);
		#1;
	endtask
	task print_verdict;
		$display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	initial begin
		#(25 * 5000);
		bad_count++;
		print_verdict;
	end
	initial begin
		reset = 1'b1;
		acc = '0;
		lsf_en = 1'b0;
		sharp = 1'b1;
		phase = 8'h6b;
		repeat (10) @(posedge clk);
		reset <= 1'b0;
		for (i = 0; i < 11; i++) rd(8'h99 + 8'(i), 8'h00);
		for (i = 0; i < 13; i++) begin
			wr(rows[i].a, rows[i].d);
			rd(rows[i].a, rows[i].r);
			chk(hit, rows[i].a inside {[8'h99:8'ha3]});
		end
		settle;
		chk({vbi.wss_enable, vbi.cgms_even_enable, vbi.cgms_odd_enable}, 3'b101);
		chk(vbi.cgms_crc_enable, 1'b0);
		chk(vbi.cgms_payload, 20'h5c35a);
		chk(vbi.wss_payload, 14'h035a);
		chk({vbi.wss_blank, col.brightness, col.hue_adjust}, 16'h9b3c);
		chk(col.luma_scale, 10'h204);
		chk(col.blue_chroma_scale, 10'h1fd);
		chk(col.red_chroma_scale, 10'h042);
		chk(col.subcarrier_phase, 10'h1af);
		chk({col.luma_shaping_filter_active, col.luma_shaping_filter_code}, 5'h06);
		chk(col.luma_shaping_filter_steps, 0);
		@(posedge clk);
		lsf_en <= 1'b1;
		for (n = 0; n < 13; n++) begin
			wr(8'ha2, 8'hf0 | 8'(n));
			settle;
			chk(col.luma_shaping_filter_code, n);
			chk(col.luma_shaping_filter_steps, n - 6);
		end
		wr(8'ha2, 8'h0f);
		settle;
		chk(col.luma_shaping_filter_code, 12);
		chk(col.luma_shaping_filter_active, 1'b1);
		for (m = 0; m < 2; m++) begin
			@(posedge clk);
			sharp <= m[0];
			for (n = 0; n < 9; n++) begin
				wr(8'ha3, {4'(n), 4'(8 - n)});
				settle;
				chk(col.border_coring_gain, m ? 8 - n : -2 * (8 - n));
				chk(col.data_coring_gain, m ? n : -2 * n);
			end
		end
		wr(8'ha3, 8'hf9);
		settle;
		chk(col.border_coring_gain, 8);
		chk(col.data_coring_gain, 8);
		@(posedge clk);
		phase <= 8'h12;
		settle;
		chk(col.subcarrier_phase[9:2], 8'h12);
		@(posedge clk);
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		for (i = 0; i < 11; i++) rd(8'h99 + 8'(i), 8'h00);
		chk(col.luma_scale, 10'h000);
		print_verdict;
	end
endmodule

bind svca_regs svca_regs_sva svca_regs_sva_inst (.clk(clk), .reset(reset), .access(access),
	.phase_msbs(phase_msbs), .luma_shaping_filter_enable(luma_shaping_filter_enable),
	.rdata(rdata), .read_valid(read_valid), .address_hit(address_hit), .vbi_cfg(vbi_cfg),
	.color_cfg(color_cfg));
